// File: flash_cmd_regs.svh
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH
// =====================================================
// Command codes of the serial instruction set
`define OP_WRITE_UNLOCK 8'h06
`define OP_WRITE_LOCK_OFF 8'h04
`define OP_LOCK_WRITE 8'he5
`define OP_LOCK_READ 8'he8
`define OP_FLAG_READ 8'h70
`define OP_FLAG_CLEAR 8'h50
`define OP_PCFG_READ 8'hb5
`define OP_PCFG_WRITE 8'hb1
`define OP_VCFG_READ 8'h85
`define OP_VCFG_WRITE 8'h81
`define OP_ECFG_READ 8'h65
`define OP_ECFG_WRITE 8'h61
`define OP_RESET_ENABLE 8'h66
`define OP_RESET_MEMORY 8'h99
// =====================================================
// Field positions
`define LOCK_DOWN_BIT 1
`define LOCK_WRITE_BIT 0
`define FLAG_READY_BIT 7
`define FLAG_ERASE_ERR_BIT 5
`define FLAG_PROG_ERR_BIT 4
`define FLAG_VPP_ERR_BIT 3
`define FLAG_PROT_ERR_BIT 1
`define FLAG_ERR_MASK 8'h3a
// =====================================================
// Reset values
`define PCFG_RESET 16'hffff
`define LOCK_RESET 2'h0
`define SECTOR_COUNT 256
// =====================================================
// Timing
`define CLK_PERIOD_NS 10
`define PCFG_WRITE_TIME_NS 200000
`define PCFG_WRITE_CYCLES (`PCFG_WRITE_TIME_NS / `CLK_PERIOD_NS)
`endif

// File: flash_cmd_pkg.sv
package flash_cmd_pkg;
    // Command phase of the serial decoder
    typedef enum logic [2:0] {
        PH_OPCODE = 3'b000,
        PH_ADDR = 3'b001,
        PH_DATA = 3'b010,
        PH_READ = 3'b011,
        PH_IGNORE = 3'b100
    } phase_e;
endpackage

// File: flash_register_command_handler.sv
`timescale 1ns/10ps
`include "flash_cmd_regs.svh"
// Operation
// - Lock write needs write-enable latch set
// - Lock write: opcode, address, byte, exact end
// - Clear write-enable latch after lock write
// - Refuse lock write during program or erase
// - Flag register readable always, repeats
// - Flag clear resets four error bits
// - Flag clear ignores and keeps latch
// - Separate reads for three configuration registers
// - Persistent write needs latch, sixteen bits
// - Select rise starts timed persistent write
// - Busy during persistent write, then clear latch
// - Persistent value applies after next power-on
// - Volatile write: latch, one byte, clears latch
// - Volatile write applies at once
// - Enhanced write: latch, byte, clears, applies
// - Reset needs enable directly before memory reset
// - Reset restores locks, volatile and address regs
// - Device enters reset on select rise
// - Write-locked sector refuses program or erase
// - Lock-down freezes sector lock bits
module flash_register_command_handler #(
    parameter int PCFG_CYCLES = `PCFG_WRITE_CYCLES // Persistent write duration
) (
    input wire logic clk, // System clock, 100 MHz
    input wire logic rst_b, // Power-on reset, sync, active low
    input wire logic sel_b_pin, // Chip select from host, active low
    input wire logic sclk_pin, // Serial clock from host
    input wire logic serial_in_line, // Serial data in
    output logic serial_out, // Serial data out
    output logic serial_out_en, // High while driving serial out
    input wire logic array_busy, // Program or erase cycle running
    input wire logic [7:0] pe_sector, // Sector targeted by program or erase
    input wire logic [3:0] err_set, // Error events: erase, program, vpp, protection
    output logic pe_allowed, // Target sector not write locked
    output logic write_enable_latch, // Write-enable latch state
    output logic write_busy_flag, // Write in progress
    output logic [7:0] vcfg_out, // Active volatile configuration
    output logic [7:0] ecfg_out, // Active enhanced configuration
    output logic [7:0] ext_addr_out, // Extended address register
    output logic [15:0] pcfg_active, // Configuration latched at power-on
    output logic soft_reset_pulse // One cycle when software reset is taken
);
    // =====================================================
    // Pin synchronisers
    logic [1:0] sel_s_r, sck_s_r, din_s_r; // Two stage sync
    logic sck_d_r; // Delayed synced clock for edge find
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sel_s_r <= 2'h3;
            sck_s_r <= 2'h0;
            din_s_r <= 2'h0;
            sck_d_r <= 1'b0;
        end else begin
            sel_s_r <= {sel_s_r[0], sel_b_pin};
            sck_s_r <= {sck_s_r[0], sclk_pin};
            din_s_r <= {din_s_r[0], serial_in_line};
            sck_d_r <= sck_s_r[1];
        end
    end
    wire sel_b = sel_s_r[1];
    wire din = din_s_r[1];
    wire sck_rise = sck_s_r[1] & ~sck_d_r;
    wire sck_fall = ~sck_s_r[1] & sck_d_r;
    logic sel_d_r; // Delayed select for edge find
    wire sel_rise = sel_b & ~sel_d_r;

    // =====================================================
    // State
    flash_cmd_pkg::phase_e phase_r, phase_nxt; // Decoder phase
    logic [7:0] shift_r; // Incoming bit shifter
    logic [2:0] bitc_r; // Bit within byte
    logic [2:0] bytec_r; // Byte within phase
    logic [7:0] opcode_r; // Captured opcode
    logic [7:0] sect_r; // Sector from first address byte
    logic [15:0] data_r; // Captured data bytes
    logic [7:0] dout_r; // Output shift register
    logic wel_r; // Write enable latch
    logic rst_arm_r; // Reset enable pending
    logic [7:0] flags_r; // Flag status register
    logic [15:0] pcfg_r = `PCFG_RESET; // Non-volatile store: power-on reset must not clear it
    logic [15:0] pcfg_live_r; // Copy taken at power-on
    logic pcfg_boot_r; // Power-on copy done
    logic [7:0] vcfg_r, ecfg_r, ext_r; // Volatile registers
    logic [1:0] lock_r [`SECTOR_COUNT]; // Per-sector lock pairs
    logic [31:0] pc_cnt_r; // Persistent write timer

    // =====================================================
    // Decode
    wire byte_done = sck_rise & ~sel_b & (bitc_r == 3'h7);
    wire [7:0] byte_in = {shift_r[6:0], din};
    wire pc_busy = (pc_cnt_r != 32'h0);
    wire busy = pc_busy | array_busy;
    wire is_lockw = (opcode_r == `OP_LOCK_WRITE);
    wire is_pcw = (opcode_r == `OP_PCFG_WRITE);
    wire is_vcw = (opcode_r == `OP_VCFG_WRITE);
    wire is_ecw = (opcode_r == `OP_ECFG_WRITE);
    // Exact byte boundary: data phase, bit count zero; each command checks its own byte count
    wire at_edge = (phase_r == flash_cmd_pkg::PH_DATA) & (bitc_r == 3'h0);
    wire lock_ok = sel_rise & at_edge & is_lockw & (bytec_r == 3'h1) & wel_r & ~busy;
    wire lock_frozen = lock_r[sect_r][`LOCK_DOWN_BIT];
    wire pcw_ok = sel_rise & at_edge & is_pcw & (bytec_r == 3'h2) & wel_r & ~busy;
    wire vcw_ok = sel_rise & at_edge & is_vcw & (bytec_r == 3'h1) & wel_r & ~busy;
    wire ecw_ok = sel_rise & at_edge & is_ecw & (bytec_r == 3'h1) & wel_r & ~busy;
    wire op_end = sel_rise & (phase_r == flash_cmd_pkg::PH_OPCODE) & (bitc_r == 3'h0) & (bytec_r == 3'h1);
    wire clr_ok = op_end & (opcode_r == `OP_FLAG_CLEAR);
    wire write_unlock_cmd_ok = op_end & (opcode_r == `OP_WRITE_UNLOCK);
    wire wrdi_ok = op_end & (opcode_r == `OP_WRITE_LOCK_OFF);
    wire rsten_ok = op_end & (opcode_r == `OP_RESET_ENABLE);
    wire rst_go = op_end & (opcode_r == `OP_RESET_MEMORY) & rst_arm_r;
    wire pc_done = (pc_cnt_r == 32'h1);

    // =====================================================
    // Reload value at the start of every byte of a read
    logic [7:0] rd_val; // Byte to shift out next
    always_comb begin
        rd_val = 8'h00;
        if (opcode_r == `OP_FLAG_READ) begin
            rd_val = {~busy, flags_r[6:0]};
        end else if (opcode_r == `OP_PCFG_READ) begin
            rd_val = pcfg_r[7:0];
        end else if (opcode_r == `OP_VCFG_READ) begin
            rd_val = vcfg_r;
        end else if (opcode_r == `OP_ECFG_READ) begin
            rd_val = ecfg_r;
        end
    end
    wire is_read_op = (byte_in == `OP_FLAG_READ) | (byte_in == `OP_PCFG_READ) |
                      (byte_in == `OP_VCFG_READ) | (byte_in == `OP_ECFG_READ);
    wire has_addr = (byte_in == `OP_LOCK_WRITE);
    wire is_pcw_in = (byte_in == `OP_PCFG_WRITE);
    wire has_data = is_pcw_in | (byte_in == `OP_VCFG_WRITE) | (byte_in == `OP_ECFG_WRITE);

    // =====================================================
    // Phase sequencing
    always_comb begin
        phase_nxt = phase_r;
        case (phase_r)
            flash_cmd_pkg::PH_OPCODE: begin
                if (byte_done & (bytec_r == 3'h0)) begin
                    if (is_read_op) begin
                        phase_nxt = flash_cmd_pkg::PH_READ;
                    end else if (has_addr) begin
                        phase_nxt = flash_cmd_pkg::PH_ADDR;
                    end else if (has_data) begin
                        phase_nxt = flash_cmd_pkg::PH_DATA;
                    end
                end else if (byte_done) begin
                    phase_nxt = flash_cmd_pkg::PH_IGNORE; // Too long for no-data op
                end
            end
            flash_cmd_pkg::PH_ADDR: begin
                if (byte_done & (bytec_r == 3'h2)) begin
                    phase_nxt = flash_cmd_pkg::PH_DATA;
                end
            end
            default: begin
                phase_nxt = phase_r;
            end
        endcase
        if (sel_b) begin
            phase_nxt = flash_cmd_pkg::PH_OPCODE;
        end
    end

    // =====================================================
    // Serial shifter and counters
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phase_r <= flash_cmd_pkg::PH_OPCODE;
            shift_r <= 8'h00;
            bitc_r <= 3'h0;
            bytec_r <= 3'h0;
            opcode_r <= 8'h00;
            sect_r <= 8'h00;
            data_r <= 16'h0000;
            dout_r <= 8'h00;
            sel_d_r <= 1'b1;
        end else begin
            sel_d_r <= sel_b;
            phase_r <= phase_nxt;
            if (sel_b) begin
                bitc_r <= 3'h0;
                bytec_r <= 3'h0;
            end else if (sck_rise) begin
                shift_r <= byte_in;
                bitc_r <= bitc_r + 3'h1;
                if (byte_done) begin
                    // Byte counter restarts when the phase moves on
                    bytec_r <= (phase_nxt != phase_r) ? 3'h0 : bytec_r + 3'h1;
                    if (phase_r == flash_cmd_pkg::PH_OPCODE && bytec_r == 3'h0) begin
                        opcode_r <= byte_in;
                        bytec_r <= (phase_nxt != phase_r) ? 3'h0 : 3'h1;
                    end
                    if (phase_r == flash_cmd_pkg::PH_ADDR && bytec_r == 3'h0) begin
                        sect_r <= byte_in; // First address byte is bits 23:16, the sector
                    end
                    if (phase_r == flash_cmd_pkg::PH_DATA) begin
                        data_r <= {data_r[7:0], byte_in};
                    end
                end
            end else if (sck_fall && phase_r == flash_cmd_pkg::PH_READ) begin
                // Each byte reloads, so the first fall shows the MSB and the flag byte repeats live
                dout_r <= (bitc_r == 3'h0) ? rd_val : {dout_r[6:0], dout_r[7]};
            end
        end
    end
    assign serial_out = dout_r[7];
    assign serial_out_en = ~sel_b & (phase_r == flash_cmd_pkg::PH_READ);

    // =====================================================
    // Write enable latch, reset arming, flags
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wel_r <= 1'b0;
            rst_arm_r <= 1'b0;
            flags_r <= 8'h00;
        end else begin
            if (write_unlock_cmd_ok) begin
                wel_r <= 1'b1;
            end else if (wrdi_ok | lock_ok | vcw_ok | ecw_ok | pc_done | rst_go) begin
                wel_r <= 1'b0;
            end
            if (sel_rise) begin
                rst_arm_r <= rsten_ok;
            end
            // New errors win over a clear in the same cycle
            flags_r <= (clr_ok ? (flags_r & ~`FLAG_ERR_MASK) : flags_r) |
                       {2'b00, err_set[3], err_set[2], err_set[1], 1'b0, err_set[0], 1'b0};
        end
    end

    // =====================================================
    // Configuration registers and persistent write timer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pcfg_live_r <= `PCFG_RESET;
            pcfg_boot_r <= 1'b0;
            vcfg_r <= 8'h00;
            ecfg_r <= 8'h00;
            ext_r <= 8'h00;
            pc_cnt_r <= 32'h0;
        end else begin
            if (!pcfg_boot_r) begin
                pcfg_live_r <= pcfg_r;
                vcfg_r <= pcfg_r[15:8];
                ecfg_r <= pcfg_r[7:0];
                pcfg_boot_r <= 1'b1;
            end else if (rst_go) begin
                vcfg_r <= pcfg_live_r[15:8];
                ecfg_r <= pcfg_live_r[7:0];
                ext_r <= 8'h00;
            end else begin
                if (vcw_ok) begin
                    vcfg_r <= data_r[7:0];
                end
                if (ecw_ok) begin
                    ecfg_r <= data_r[7:0];
                end
            end
            if (pcw_ok) begin
                pcfg_r <= {data_r[7:0], data_r[15:8]}; // Low byte sent first
                pc_cnt_r <= PCFG_CYCLES[31:0];
            end else if (pc_busy) begin
                pc_cnt_r <= pc_cnt_r - 32'h1;
            end
        end
    end

    // =====================================================
    // Sector lock array
    always_ff @(posedge clk) begin
        if (!rst_b || rst_go) begin
            for (int i = 0; i < `SECTOR_COUNT; i++) begin
                lock_r[i] <= `LOCK_RESET;
            end
        end else if (lock_ok && !lock_frozen) begin
            lock_r[sect_r] <= data_r[1:0];
        end
    end

    assign pe_allowed = ~lock_r[pe_sector][`LOCK_WRITE_BIT];
    assign write_enable_latch = wel_r;
    assign write_busy_flag = pc_busy;
    assign vcfg_out = vcfg_r;
    assign ecfg_out = ecfg_r;
    assign ext_addr_out = ext_r;
    assign pcfg_active = pcfg_live_r;
    assign soft_reset_pulse = rst_go;

    // =====================================================
    // Checks
    property p_lock_wel;
        @(posedge clk) disable iff (!rst_b) lock_ok |=> !wel_r;
    endproperty
    a_lock_wel: assert property (p_lock_wel) else $error("latch not cleared after lock write");
    property p_lock_busy;
        @(posedge clk) disable iff (!rst_b) (busy && !rst_go) |=> lock_r[$past(sect_r)] == $past(lock_r[sect_r]);
    endproperty
    a_lock_busy: assert property (p_lock_busy) else $error("lock write taken while busy");
    property p_clr_wel;
        @(posedge clk) disable iff (!rst_b) (clr_ok && !pc_done) |=> wel_r == $past(wel_r);
    endproperty
    a_clr_wel: assert property (p_clr_wel) else $error("flag clear changed latch");
    property p_pc_busy;
        @(posedge clk) disable iff (!rst_b) pcw_ok |=> write_busy_flag [*8];
    endproperty
    a_pc_busy: assert property (p_pc_busy) else $error("persistent write not busy");
    property p_vcw;
        @(posedge clk) disable iff (!rst_b) (vcw_ok && pcfg_boot_r) |=> vcfg_r == $past(data_r[7:0]) && !wel_r;
    endproperty
    a_vcw: assert property (p_vcw) else $error("volatile write wrong");
    property p_nowel;
        @(posedge clk) disable iff (!rst_b) (sel_rise && !wel_r && !rst_go && pcfg_boot_r) |=>
            $stable(vcfg_r) && $stable(ecfg_r) && $stable(pcfg_r);
    endproperty
    a_nowel: assert property (p_nowel) else $error("write without latch");
    property p_arm;
        @(posedge clk) disable iff (!rst_b) rst_go |-> $past(rst_arm_r);
    endproperty
    a_arm: assert property (p_arm) else $error("reset without enable");
    property p_pcfg_hold;
        @(posedge clk) disable iff (!rst_b) pcfg_boot_r && $past(pcfg_boot_r) |-> $stable(pcfg_live_r);
    endproperty
    a_pcfg_hold: assert property (p_pcfg_hold) else $error("active config changed");
    c_lock: cover property (@(posedge clk) lock_ok);
    c_pcw: cover property (@(posedge clk) pcw_ok ##[1:1000] pc_done);
    c_rst: cover property (@(posedge clk) rst_go);
endmodule // flash_register_command_handler

// File: spi_host_model.sv
`timescale 1ns/10ps
// =====================================================
// Serial host: mode 0, link clock idle low and still between frames
module spi_host_model (
    input wire logic clk, // System clock
    output logic sel_b_pin, // Chip select, active low
    output logic sclk_pin, // Link clock, 160 ns period
    output logic serial_in_line, // Data towards the device
    input wire logic serial_out // Data from the device
);
    localparam int HALF = 8; // Half link period in clk cycles
    // Idle state at time zero
    initial begin
        sel_b_pin = 1'b1;
        sclk_pin = 1'b0;
        serial_in_line = 1'b0;
    end
    // Wait n edges, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One frame: top nbits of tx out, then nrd bits read back
    task automatic frame(input logic [39:0] tx, input int nbits, input int nrd, output logic [15:0] rx);
        rx = 16'h0;
        sel_b_pin = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            serial_in_line = tx[39 - i]; // MSB first
            tick(HALF);
            sclk_pin = 1'b1;
            tick(HALF);
            sclk_pin = 1'b0;
        end
        // Line is meaningless now, so it must not look like the last bit
        serial_in_line = ~serial_in_line;
        for (int i = 0; i < nrd; i++) begin
            tick(HALF);
            rx = {rx[14:0], serial_out}; // Sampled just before the rising edge
            sclk_pin = 1'b1;
            tick(HALF);
            sclk_pin = 1'b0;
        end
        tick(HALF);
        sel_b_pin = 1'b1; // Select rises half a link period after the last bit
    endtask
endmodule // spi_host_model

// File: testbench.sv
`timescale 1ns/10ps
`include "flash_cmd_regs.svh"
// =====================================================
// Register command bench driving a serial host model
module testbench;
    localparam int PCFG_N = 20; // Shortened persistent write time
    logic clk; // System clock
    logic rst_b; // Reset, active low
    logic array_busy; // Program or erase running
    logic [7:0] pe_sector; // Sector asked about
    logic [3:0] err_set; // Error events
    wire sel_b_pin, sclk_pin, serial_in_line, serial_out, serial_out_en, pe_allowed;
    wire write_enable_latch, write_busy_flag, soft_reset_pulse;
    wire [7:0] vcfg_out, ecfg_out, ext_addr_out;
    wire [15:0] pcfg_active;
    logic [15:0] rx; // Last read back value
    int n_fail = 0;
    int checks = 0;
    int n_pulse = 0; // Software resets seen
    int n_oe = 0; // Cycles with serial out driven
    int n; // Cycle count of a wait
    // Clock of 10 ns
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Count pulses and drive cycles midway between edges, where outputs are settled
    always @(negedge clk) begin
        if (soft_reset_pulse === 1'b1) n_pulse <= n_pulse + 1;
        if (serial_out_en === 1'b1) n_oe <= n_oe + 1;
    end
    flash_register_command_handler #(.PCFG_CYCLES(PCFG_N)) flash_register_command_handler_i (
        .clk(clk), .rst_b(rst_b), .sel_b_pin(sel_b_pin), .sclk_pin(sclk_pin),
        .serial_in_line(serial_in_line), .serial_out(serial_out), .serial_out_en(serial_out_en),
        .array_busy(array_busy), .pe_sector(pe_sector), .err_set(err_set), .pe_allowed(pe_allowed),
        .write_enable_latch(write_enable_latch), .write_busy_flag(write_busy_flag),
        .vcfg_out(vcfg_out), .ecfg_out(ecfg_out), .ext_addr_out(ext_addr_out),
        .pcfg_active(pcfg_active), .soft_reset_pulse(soft_reset_pulse));
    spi_host_model spi_host_model_i (
        .clk(clk), .sel_b_pin(sel_b_pin), .sclk_pin(sclk_pin),
        .serial_in_line(serial_in_line), .serial_out(serial_out));
    // =====================================================
    // Helpers
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Frame plus a deselect gap long enough for reset gap and recovery
    task automatic send(input logic [39:0] tx, input int nbits, input int nrd);
        spi_host_model_i.frame(tx, nbits, nrd, rx);
        spi_host_model_i.tick(16);
    endtask
    // Write preceded by write-unlock
    task automatic wsend(input logic [39:0] tx, input int nbits);
        send({`OP_WRITE_UNLOCK, 32'h0}, 8, 0);
        send(tx, nbits, 0);
    endtask
    // Bounded wait while busy flag differs from lvl
    task automatic wait_busy(input logic lvl, input int bound);
        n = 0;
        while (write_busy_flag !== lvl && n < bound) begin
            spi_host_model_i.tick(1);
            n++;
        end
        if (n >= bound) begin
            n_fail++;
            end_of_test();
        end
    endtask
    task automatic power_on;
        rst_b = 1'b0;
        spi_host_model_i.tick(2);
        rst_b = 1'b1;
        spi_host_model_i.tick(4);
    endtask
    // =====================================================
    // Main sequence
    initial begin
        array_busy = 1'b0;
        pe_sector = 8'h12;
        err_set = 4'h0;
        power_on();
        check(write_enable_latch, 1'b0);
        check(write_busy_flag, 1'b0);
        check(pcfg_active, `PCFG_RESET);
        check({vcfg_out, ecfg_out}, 16'hffff);
        check(pe_allowed, 1'b1);
        $display("test reset_state done");
        // Flags: repeat, error clear, latch kept
        send({`OP_FLAG_READ, 32'h0}, 8, 8);
        check(rx[7:0], 8'h80);
        check(n_oe > 100 && n_oe < 160, 1'b1);
        err_set = 4'h5; // Program and protection errors
        spi_host_model_i.tick(1);
        err_set = 4'h0;
        send({`OP_FLAG_READ, 32'h0}, 8, 8);
        check(rx[7:0], 8'h92);
        err_set = 4'ha; // Erase and vpp errors
        spi_host_model_i.tick(1);
        err_set = 4'h0;
        send({`OP_FLAG_READ, 32'h0}, 8, 16);
        check(rx, 16'hbaba);
        send({`OP_WRITE_UNLOCK, 32'h0}, 8, 0);
        send({`OP_FLAG_CLEAR, 32'h0}, 8, 0);
        check(write_enable_latch, 1'b1);
        send({`OP_FLAG_READ, 32'h0}, 8, 8);
        check(rx[7:0], 8'h80);
        $display("test flags done");
        // Volatile and enhanced writes, refused and accepted
        send({`OP_WRITE_LOCK_OFF, 32'h0}, 8, 0);
        send({`OP_VCFG_WRITE, 8'h5a, 24'h0}, 16, 0);
        check(vcfg_out, 8'hff);
        wsend({`OP_VCFG_WRITE, 8'h5a, 24'h0}, 15);
        check(vcfg_out, 8'hff);
        wsend({`OP_VCFG_WRITE, 8'ha5, 24'h0}, 16);
        check({vcfg_out, 7'h0, write_enable_latch}, 16'ha500);
        wsend({`OP_ECFG_WRITE, 8'h3c, 24'h0}, 15);
        check(ecfg_out, 8'hff);
        wsend({`OP_ECFG_WRITE, 8'h3c, 24'h0}, 16);
        check({ecfg_out, 7'h0, write_enable_latch}, 16'h3c00);
        send({`OP_VCFG_READ, 32'h0}, 8, 8);
        check(rx[7:0], 8'ha5);
        send({`OP_ECFG_READ, 32'h0}, 8, 8);
        check(rx[7:0], 8'h3c);
        $display("test config done");
        // Sector locks; data bytes keep b7-b2 zero
        wsend({`OP_LOCK_WRITE, 24'h120000, 8'h01}, 39);
        check(pe_allowed, 1'b1);
        wsend({`OP_LOCK_WRITE, 24'h120000, 8'h01}, 40);
        check(pe_allowed, 1'b0);
        check(write_enable_latch, 1'b0);
        wsend({`OP_LOCK_WRITE, 24'h120000, 8'h00}, 40);
        check(pe_allowed, 1'b1);
        wsend({`OP_LOCK_WRITE, 24'h120000, 8'h03}, 40);
        wsend({`OP_LOCK_WRITE, 24'h120000, 8'h00}, 40);
        check(pe_allowed, 1'b0);
        wsend({`OP_LOCK_WRITE, 24'hc90000, 8'h01}, 40);
        pe_sector = 8'hc9;
        spi_host_model_i.tick(1);
        check(pe_allowed, 1'b0);
        pe_sector = 8'h34;
        spi_host_model_i.tick(1);
        check(pe_allowed, 1'b1);
        // Lock write while the array is busy
        send({`OP_WRITE_UNLOCK, 32'h0}, 8, 0);
        array_busy = 1'b1;
        send({`OP_FLAG_READ, 32'h0}, 8, 8);
        check(rx[7], 1'b0);
        send({`OP_LOCK_WRITE, 24'h340000, 8'h01}, 40, 0);
        check(pe_allowed, 1'b1);
        array_busy = 1'b0;
        $display("test locks done");
        // Software reset: disarmed, then accepted
        send({`OP_RESET_ENABLE, 32'h0}, 8, 0);
        send({`OP_FLAG_READ, 32'h0}, 8, 8);
        send({`OP_RESET_MEMORY, 32'h0}, 8, 0);
        check({n_pulse[7:0], vcfg_out}, 16'h00a5);
        send({`OP_RESET_ENABLE, 32'h0}, 8, 0);
        send({`OP_RESET_MEMORY, 32'h0}, 8, 0);
        check(n_pulse[15:0], 16'h1);
        check({vcfg_out, ecfg_out}, 16'hffff);
        check(ext_addr_out, 8'h00);
        pe_sector = 8'h12;
        spi_host_model_i.tick(1);
        check(pe_allowed, 1'b1);
        $display("test soft_reset done");
        // Persistent write: short frame refused, full frame timed
        wsend({`OP_PCFG_WRITE, 8'h12, 24'h0}, 16);
        check(write_busy_flag, 1'b0);
        send({`OP_WRITE_UNLOCK, 32'h0}, 8, 0);
        spi_host_model_i.frame({`OP_PCFG_WRITE, 8'h12, 8'h34, 16'h0}, 24, 0, rx);
        wait_busy(1'b1, 8);
        check(write_busy_flag, 1'b1);
        wait_busy(1'b0, 40); // Poll before the next instruction
        check(n >= PCFG_N - 1 && n <= PCFG_N + 1, 1'b1);
        check(write_enable_latch, 1'b0);
        check(pcfg_active, `PCFG_RESET);
        spi_host_model_i.tick(16);
        send({`OP_PCFG_READ, 32'h0}, 8, 8);
        check(rx[7:0], 8'h12);
        power_on();
        check(pcfg_active, 16'h3412);
        $display("test persistent done");
        end_of_test();
    end
endmodule // testbench
